// [cpu_interrupt_controller.sv]
`timescale 1ns/1ns
module cpu_interrupt_controller #(
  parameter int NVEC = 64
) (
  input  wire logic                 clk_sys_i,
  input  wire logic                 rst_n_i,
  input  wire intc_pkg::avs_req_t   avs_req_i,
  output logic [31:0]               avs_readdata_o,
  output logic                      avs_waitrequest_o,
  input  wire intc_pkg::core_evt_t  core_evt_i,
  input  wire logic                 global_int_en_i,
  input  wire logic                 nmi_req_i,
  input  wire logic [NVEC-1:0]      vec_req_i,
  input  wire logic                 boot_whole_mem_i,
  output logic                      irq_req_o,
  output intc_pkg::lvl_t            irq_level_o,
  output logic [7:0]                irq_vector_o,
  output logic                      vect_at_boot_start_o,
  output logic                      compact_table_o,
  output logic [15:0]               reset_pc_o
);

  localparam int VW = $clog2(NVEC);

  // Vector count must be a power of two that fits the 8-bit vector numbers
  if (NVEC < 4 || NVEC > 256 || (NVEC & (NVEC - 1)) != 0) begin : g_chk
    $error("NVEC must be a power of two from 4 to 256");
  end

  intc_pkg::intc_state_t s_r;
  intc_pkg::intc_state_t s_nxt;

  // Rotating search: vector after the pointer first, pointer itself last
  function automatic logic [8:0] pick_l0(input logic [NVEC-1:0] req,
                                         input logic [7:0]      ptr);
    logic       found;
    logic [7:0] vec;
    logic [7:0] idx;
    found = 1'b0;
    vec   = intc_pkg::VEC_NONE;
    for (int i = 1; i <= NVEC; i++) begin
      idx = (ptr + 8'(i)) & 8'(NVEC - 1); // RULE16
      if (!found && req[idx[VW-1:0]]) begin
        found = 1'b1;
        vec   = idx;
      end
    end
    return {found, vec};
  endfunction : pick_l0

  // Next-state logic for bus, protection, arbitration and status
  always_comb begin
    logic [NVEC-1:0] l0_cand;
    logic [8:0]      l0_pick;
    logic            l1_valid;
    logic            l1_pend;
    logic            accept;
    logic            wr_en;
    logic [7:0]      wbyte;
    logic [7:0]      rbyte;
    l0_cand  = '0;
    l0_pick  = '0;
    l1_valid = 1'b0;
    l1_pend  = 1'b0;
    accept   = 1'b0;
    wr_en    = 1'b0;
    wbyte    = avs_req_i.writedata[7:0];
    rbyte    = intc_pkg::REG_RESET;
    s_nxt    = s_r;

    // Key window opens on unlock and counts down per retired instruction
    if (core_evt_i.key_unlock) begin
      s_nxt.win_cnt = intc_pkg::KEY_WINDOW_INSNS; // RULE1
    end else if (core_evt_i.insn_retire &&
                 s_r.win_cnt != intc_pkg::WINDOW_CLOSED) begin
      s_nxt.win_cnt = s_r.win_cnt - 3'h1; // RULE1
    end

    // Read mux; unused bits and unmapped addresses read zero
    case (avs_req_i.address[3:2])
      intc_pkg::IDX_CONTROL: begin
        rbyte[intc_pkg::CTL_PLACE_BIT]   = s_r.place_sel;
        rbyte[intc_pkg::CTL_COMPACT_BIT] = s_r.compact_en;
        rbyte[intc_pkg::CTL_RR_BIT]      = s_r.rr_en; // RULE20
      end
      intc_pkg::IDX_EXEC_LVLS: begin
        rbyte[intc_pkg::ST_NMI_BIT] = s_r.nmi_ex;
        rbyte[intc_pkg::ST_L1_BIT]  = s_r.l1_ex;
        rbyte[intc_pkg::ST_L0_BIT]  = s_r.l0_ex; // RULE20
      end
      intc_pkg::IDX_L0_PTR: rbyte = s_r.l0_ptr;
      intc_pkg::IDX_L1_VEC: rbyte = s_r.l1_vec;
      default: rbyte = intc_pkg::REG_RESET;
    endcase

    // Bus: one wait cycle, then the transfer completes
    case (s_r.phase)
      intc_pkg::BUS_IDLE: begin
        if (avs_req_i.read || avs_req_i.write) begin
          s_nxt.phase = intc_pkg::BUS_ANSWER;
          s_nxt.rdata = intc_pkg::RDATA_ZERO;
          if (avs_req_i.read && avs_req_i.address[1:0] == 2'h0) begin
            s_nxt.rdata[7:0] = rbyte;
          end
        end
      end
      intc_pkg::BUS_ANSWER: begin
        s_nxt.phase = intc_pkg::BUS_IDLE;
        wr_en = avs_req_i.write && avs_req_i.byteenable[0] &&
                avs_req_i.address[1:0] == 2'h0;
      end
      default: s_nxt.phase = intc_pkg::BUS_IDLE;
    endcase

    // Register writes
    if (wr_en) begin
      case (avs_req_i.address[3:2])
        intc_pkg::IDX_CONTROL: begin
          s_nxt.rr_en = wbyte[intc_pkg::CTL_RR_BIT]; // RULE4
          if (s_r.win_cnt != intc_pkg::WINDOW_CLOSED) begin // RULE2
            s_nxt.place_sel  = wbyte[intc_pkg::CTL_PLACE_BIT]; // RULE3
            s_nxt.compact_en = wbyte[intc_pkg::CTL_COMPACT_BIT]; // RULE3
            // A fresh key in the same cycle keeps the window open
            if (!core_evt_i.key_unlock) begin
              s_nxt.win_cnt = intc_pkg::WINDOW_CLOSED; // RULE1
            end
          end
        end
        intc_pkg::IDX_L0_PTR: s_nxt.l0_ptr = wbyte; // RULE14
        intc_pkg::IDX_L1_VEC: s_nxt.l1_vec = wbyte; // RULE15
        default: s_nxt.l0_ptr = s_nxt.l0_ptr;
      endcase
    end

    // Level 1 request: vector zero or out of range disables it
    l1_valid = s_r.l1_vec != intc_pkg::VEC_NONE &&
               {1'b0, s_r.l1_vec} < 9'(NVEC); // RULE15
    l1_pend  = l1_valid && vec_req_i[s_r.l1_vec[VW-1:0]];

    // Level 0 candidates exclude reset, the fixed NMI vector and level 1
    for (int v = intc_pkg::FIRST_L0_VEC; v < NVEC; v++) begin
      l0_cand[v] = vec_req_i[v] &&
                   !(l1_valid && s_r.l1_vec == 8'(v));
    end
    // Fixed mode keeps the written pointer; RR mode keeps the last ack
    l0_pick = pick_l0(l0_cand, s_r.l0_ptr); // RULE9 RULE14

    // Return clears the innermost executing level only
    if (core_evt_i.return_from_interrupt) begin
      if (s_r.nmi_ex) begin
        s_nxt.nmi_ex = 1'b0; // RULE10 RULE13
      end else if (s_r.l1_ex) begin
        s_nxt.l1_ex = 1'b0; // RULE11 RULE13
      end else begin
        s_nxt.l0_ex = 1'b0; // RULE12 RULE13
      end
    end

    // Acknowledge enters the presented level; set wins over a return
    accept = core_evt_i.irq_ack && s_r.pres_lvl != intc_pkg::LVL_NONE;
    if (accept) begin
      case (s_r.pres_lvl)
        intc_pkg::LVL_NMI: s_nxt.nmi_ex = 1'b1; // RULE10
        intc_pkg::LVL_1:   s_nxt.l1_ex  = 1'b1; // RULE11
        intc_pkg::LVL_0: begin
          s_nxt.l0_ex = 1'b1; // RULE12
          if (s_r.rr_en) begin
            s_nxt.l0_ptr = s_r.pres_vec; // RULE17
          end
        end
        default: s_nxt.l0_ex = s_nxt.l0_ex;
      endcase
    end

    // Choose what to present; outer levels stay set while preempted
    s_nxt.pres_lvl = intc_pkg::LVL_NONE;
    s_nxt.pres_vec = intc_pkg::VEC_NONE;
    s_nxt.out_vec  = intc_pkg::VEC_NONE;
    if (accept) begin
      s_nxt.pres_lvl = intc_pkg::LVL_NONE;
    end else if (nmi_req_i && !s_r.nmi_ex) begin
      s_nxt.pres_lvl = intc_pkg::LVL_NMI;
      s_nxt.pres_vec = intc_pkg::VEC_NMI;
      s_nxt.out_vec  = s_nxt.compact_en ? intc_pkg::CVT_NMI_VEC
                                        : intc_pkg::VEC_NMI; // RULE8 RULE18
    end else if (l1_pend && global_int_en_i &&
                 !s_r.nmi_ex && !s_r.l1_ex) begin // RULE19
      s_nxt.pres_lvl = intc_pkg::LVL_1;
      s_nxt.pres_vec = s_r.l1_vec;
      s_nxt.out_vec  = s_nxt.compact_en ? intc_pkg::CVT_L1_VEC
                                        : s_r.l1_vec; // RULE18
    end else if (l0_pick[8] && global_int_en_i &&
                 !s_r.nmi_ex && !s_r.l1_ex && !s_r.l0_ex) begin
      s_nxt.pres_lvl = intc_pkg::LVL_0;
      s_nxt.pres_vec = l0_pick[7:0];
      s_nxt.out_vec  = s_nxt.compact_en ? intc_pkg::CVT_L0_VEC
                                        : l0_pick[7:0]; // RULE18
    end
  end

  // State register, synchronous active-low reset
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      s_r <= '{phase:      intc_pkg::BUS_IDLE,
               rdata:      intc_pkg::RDATA_ZERO,
               place_sel:  1'b0,
               compact_en: 1'b0,
               rr_en:      1'b0,
               nmi_ex:     1'b0,
               l1_ex:      1'b0,
               l0_ex:      1'b0,
               l0_ptr:     intc_pkg::REG_RESET,
               l1_vec:     intc_pkg::REG_RESET,
               win_cnt:    intc_pkg::WINDOW_CLOSED,
               pres_lvl:   intc_pkg::LVL_NONE,
               pres_vec:   intc_pkg::VEC_NONE,
               out_vec:    intc_pkg::VEC_NONE};
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs
  assign avs_waitrequest_o = (avs_req_i.read || avs_req_i.write) &&
                             s_r.phase == intc_pkg::BUS_IDLE;
  assign avs_readdata_o    = s_r.rdata;
  assign irq_req_o         = s_r.pres_lvl != intc_pkg::LVL_NONE;
  assign irq_level_o       = s_r.pres_lvl;
  assign irq_vector_o      = s_r.out_vec;
  assign vect_at_boot_start_o = s_r.place_sel && !boot_whole_mem_i; // RULE5 RULE6
  assign compact_table_o   = s_r.compact_en; // RULE8
  assign reset_pc_o        = intc_pkg::RESET_PC; // RULE7

  // Checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  sequence ctl_write_s;
    s_r.phase == intc_pkg::BUS_ANSWER && avs_req_i.write &&
    avs_req_i.byteenable[0] && avs_req_i.address == 4'h0;
  endsequence

  sequence ctl_read_s;
    s_r.phase == intc_pkg::BUS_ANSWER && avs_req_i.read &&
    avs_req_i.address == 4'h0;
  endsequence

  sequence bus_req_s;
    (avs_req_i.read || avs_req_i.write) && s_r.phase == intc_pkg::BUS_IDLE;
  endsequence

  sequence l0_ack_s;
    core_evt_i.irq_ack && s_r.pres_lvl == intc_pkg::LVL_0;
  endsequence

  sequence l1_ack_s;
    core_evt_i.irq_ack && s_r.pres_lvl == intc_pkg::LVL_1;
  endsequence

  bus_wait_once_a: assert property (bus_req_s |-> avs_waitrequest_o ##1
                                    !avs_waitrequest_o)
    else $error("bus answer not after one wait cycle");
  prot_locked_a: assert property ( // RULE2
    ctl_write_s ##0 s_r.win_cnt == intc_pkg::WINDOW_CLOSED |=>
    $stable(s_r.place_sel) && $stable(s_r.compact_en))
    else $error("protected bit changed without unlock");
  prot_open_a: assert property ( // RULE3
    ctl_write_s ##0 s_r.win_cnt != intc_pkg::WINDOW_CLOSED |=>
    s_r.place_sel == $past(avs_req_i.writedata[intc_pkg::CTL_PLACE_BIT]) &&
    s_r.compact_en == $past(avs_req_i.writedata[intc_pkg::CTL_COMPACT_BIT]))
    else $error("protected bits not written inside the window");
  rr_free_a: assert property ( // RULE4
    ctl_write_s |=>
    s_r.rr_en == $past(avs_req_i.writedata[intc_pkg::CTL_RR_BIT]))
    else $error("round robin bit not written");
  window_len_a: assert property ( // RULE1
    core_evt_i.key_unlock |=> s_r.win_cnt == intc_pkg::KEY_WINDOW_INSNS)
    else $error("key window not opened to four");
  nmi_enter_a: assert property ( // RULE10
    core_evt_i.irq_ack && s_r.pres_lvl == intc_pkg::LVL_NMI |=>
    s_r.nmi_ex && !irq_req_o)
    else $error("nmi executing flag not set on ack");
  nmi_mask_a: assert property ( // RULE10
    s_r.nmi_ex |-> !irq_req_o)
    else $error("request presented during a non-maskable handler");
  l1_enter_a: assert property ( // RULE11
    l1_ack_s |=> s_r.l1_ex && !irq_req_o)
    else $error("level 1 executing flag not set on ack");
  l0_enter_a: assert property ( // RULE12
    l0_ack_s |=> s_r.l0_ex && !irq_req_o)
    else $error("level 0 executing flag not set on ack");
  return_from_interrupt_inner_a: assert property ( // RULE13
    core_evt_i.return_from_interrupt && !core_evt_i.irq_ack && s_r.nmi_ex && s_r.l1_ex |=>
    !s_r.nmi_ex && s_r.l1_ex)
    else $error("return cleared the wrong level");
  cvt_l0_vec_a: assert property ( // RULE18
    irq_level_o == intc_pkg::LVL_0 && compact_table_o |->
    irq_vector_o == intc_pkg::CVT_L0_VEC)
    else $error("compact level 0 vector not three");
  l1_preempt_a: assert property ( // RULE19 RULE15
    irq_level_o == intc_pkg::LVL_1 |->
    !s_r.l1_ex && !s_r.nmi_ex && $past(s_r.l1_vec) != intc_pkg::VEC_NONE)
    else $error("level 1 presented while blocked or disabled");
  ctl_unused_a: assert property ( // RULE20
    ctl_read_s |-> avs_readdata_o[31:7] == '0 &&
    avs_readdata_o[4:1] == '0)
    else $error("unused control bits read nonzero");
  rr_load_a: assert property ( // RULE17
    core_evt_i.irq_ack && s_r.rr_en && irq_level_o == intc_pkg::LVL_0 |=>
    s_r.l0_ptr == $past(s_r.pres_vec))
    else $error("round robin pointer not loaded");

endmodule : cpu_interrupt_controller

// [intc_pkg.sv]
// How it works
// RULE1: Key write opens a four-instruction window for protected control writes.
// RULE2: Protected bits stay unchanged when written without an open window.
// RULE3: Only placement and compact-table bits are protected, by register-class key.
// RULE4: Round robin enable bit is writable at any time without a key.
// RULE5: Control bit 6 picks vector placement: after or at start of boot.
// RULE6: Placement bit is ignored when the whole memory is boot section.
// RULE7: System reset always starts the program counter at address zero.
// RULE8: Control bit 5 turns the compact vector table on or off.
// RULE9: Control bit 0 picks fixed or round robin level 0 arbitration.
// RULE10: Status bit 7 flags a running non-maskable handler until its return.
// RULE11: Status bit 1 flags a running level 1 handler, also when preempted.
// RULE12: Status bit 0 flags a running level 0 handler, also when preempted.
// RULE13: Each return clears only the innermost executing level, restoring the prior.
// RULE14: Eight-bit level 0 priority pointer changes level 0 request ordering.
// RULE15: Level 1 vector register names one vector; zero disables level 1.
// RULE16: Pointer vector is lowest level 0 priority, next vector highest, wrapping.
// RULE17: Round robin mode loads the pointer with each acknowledged level 0 vector.
// RULE18: Compact table maps non-maskable to 1, level 1 to 2, level 0 to 3.
// RULE19: A level 1 request preempts a running level 0 handler.
// RULE20: Unused control and status bits read zero and ignore writes.
package intc_pkg;

  // Register indices; byte address is four times the index
  localparam logic [1:0] IDX_CONTROL   = 2'h0;
  localparam logic [1:0] IDX_EXEC_LVLS = 2'h1;
  localparam logic [1:0] IDX_L0_PTR    = 2'h2;
  localparam logic [1:0] IDX_L1_VEC    = 2'h3;

  // Field positions
  localparam int CTL_PLACE_BIT  = 6;
  localparam int CTL_COMPACT_BIT = 5;
  localparam int CTL_RR_BIT     = 0;
  localparam int ST_NMI_BIT     = 7;
  localparam int ST_L1_BIT      = 1;
  localparam int ST_L0_BIT      = 0;

  // Reset values and fixed codes
  localparam logic [7:0]  REG_RESET   = 8'h00;
  localparam logic [15:0] RESET_PC    = 16'h0000;
  localparam logic [7:0]  VEC_NMI     = 8'h01;
  localparam logic [7:0]  VEC_NONE    = 8'h00;
  localparam logic [7:0]  CVT_NMI_VEC = 8'h01;
  localparam logic [7:0]  CVT_L1_VEC  = 8'h02;
  localparam logic [7:0]  CVT_L0_VEC  = 8'h03;
  localparam int          FIRST_L0_VEC = 2;
  localparam logic [31:0] RDATA_ZERO  = 32'h0000_0000;

  // Protected-write window in retired instructions
  localparam logic [2:0]  KEY_WINDOW_INSNS = 3'h4;
  localparam logic [2:0]  WINDOW_CLOSED    = 3'h0;

  // Interrupt level being presented, Gray along none-0-1-nmi
  typedef enum logic [1:0] {
    LVL_NONE = 2'b00,
    LVL_0    = 2'b01,
    LVL_1    = 2'b11,
    LVL_NMI  = 2'b10
  } lvl_t;

  // Bus slave phase
  typedef enum logic {
    BUS_IDLE   = 1'b0,
    BUS_ANSWER = 1'b1
  } bus_phase_t;

  // Avalon-MM request from the master
  typedef struct packed {
    logic [3:0]  address;
    logic        read;
    logic        write;
    logic [3:0]  byteenable;
    logic [31:0] writedata;
  } avs_req_t;

  // Pulses from the processor core
  typedef struct packed {
    logic key_unlock;
    logic insn_retire;
    logic irq_ack;
    logic return_from_interrupt;
  } core_evt_t;

  // Whole state of the controller
  typedef struct packed {
    bus_phase_t  phase;
    logic [31:0] rdata;
    logic        place_sel;
    logic        compact_en;
    logic        rr_en;
    logic        nmi_ex;
    logic        l1_ex;
    logic        l0_ex;
    logic [7:0]  l0_ptr;
    logic [7:0]  l1_vec;
    logic [2:0]  win_cnt;
    lvl_t        pres_lvl;
    logic [7:0]  pres_vec;
    logic [7:0]  out_vec;
  } intc_state_t;

endpackage : intc_pkg

// [intc_core_model.sv]
`timescale 1ns/1ns
module intc_core_model (
  input  wire logic           clk_sys_i,
  input  wire logic           rst_n_i,
  input  wire logic           irq_req_i,
  input  wire logic           ack_en_i,
  input  wire logic [1:0]     ack_dly_i,
  output intc_pkg::core_evt_t core_evt_o
);
  logic       ack_r;
  logic       key_r;
  logic       ret_r;
  logic       rti_r;
  logic [1:0] cnt_r;

  // Pulses in the order of the event struct
  assign core_evt_o = {key_r, rti_r, ack_r, ret_r};

  // Core takes a presented request after a chosen number of cycles
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i || ack_r || !irq_req_i || !ack_en_i) begin
      ack_r <= 1'b0;
      cnt_r <= 2'h0;
    end else if (cnt_r == ack_dly_i) begin
      ack_r <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 2'h1;
    end
  end

  initial begin
    key_r = 1'b0;
    ret_r = 1'b0;
    rti_r = 1'b0;
  end

  // Key write, then n instructions retire before the next store
  task automatic unlock(input int n);
    @(posedge clk_sys_i);
    key_r <= 1'b1;
    @(posedge clk_sys_i);
    key_r <= 1'b0;
    rti_r <= 1'b1;
    repeat (n) @(posedge clk_sys_i);
    rti_r <= 1'b0;
  endtask : unlock

  // One return from the running handler
  task automatic ret;
    @(posedge clk_sys_i);
    ret_r <= 1'b1;
    @(posedge clk_sys_i);
    ret_r <= 1'b0;
  endtask : ret
endmodule : intc_core_model

// [cpu_interrupt_priority_ctrl_tb_top.sv]
`timescale 1ns/1ns
module cpu_interrupt_priority_ctrl_tb_top;
  localparam int NV = 16;
  logic                clk, rst_n, gie, nmi, boot, ack_en, irq, wt;
  logic                place, compact_table_enable;
  logic [1:0]          dly;
  logic [3:0]          be;
  logic [7:0]          vec, p;
  logic [15:0]         pc, m;
  logic [31:0]         rd, rq, r;
  logic [NV-1:0]       vreq;
  intc_pkg::lvl_t      lvl;
  intc_pkg::avs_req_t  req;
  intc_pkg::core_evt_t evt;
  int                  fail_count, tests_run, seed, c, i;

  cpu_interrupt_controller #(.NVEC(NV)) u_cpu_interrupt_controller (
    .clk_sys_i(clk), .rst_n_i(rst_n), .avs_req_i(req),
    .avs_readdata_o(rd), .avs_waitrequest_o(wt), .core_evt_i(evt),
    .global_int_en_i(gie), .nmi_req_i(nmi), .vec_req_i(vreq),
    .boot_whole_mem_i(boot), .irq_req_o(irq), .irq_level_o(lvl),
    .irq_vector_o(vec), .vect_at_boot_start_o(place),
    .compact_table_o(compact_table_enable), .reset_pc_o(pc));

  intc_core_model u_intc_core_model (
    .clk_sys_i(clk), .rst_n_i(rst_n), .irq_req_i(irq),
    .ack_en_i(ack_en), .ack_dly_i(dly), .core_evt_o(evt));

  // Free-running system clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Hang guard
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    end_of_test;
  end

  // Fixed-mode winner: the vector after the pointer ranks first
  function automatic logic [7:0] win(input logic [15:0] mk,
                                     input logic [7:0] ptr);
    int k, v;
    win = 8'h00;
    for (k = NV; k >= 1; k--) begin
      v = (ptr + k) % NV;
      if (v > 1 && mk[v]) win = v[7:0];
    end
  endfunction : win

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  // One Avalon transfer, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    req.address <= a;
    req.read <= !w;
    req.write <= w;
    req.byteenable <= be;
    req.writedata <= {24'h00_0000, d};
    // Waitrequest is sampled at rising edges; the low one ends the transfer
    @(posedge clk);
    while (wt !== 1'b0 && n < 40) begin
      @(posedge clk);
      n++;
    end
    if (n >= 40) fail_count++;
    rq = rd;
    req.read <= 1'b0;
    req.write <= 1'b0;
  endtask : bus

  task automatic rchk(input logic [3:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(rq, {24'h00_0000, e});
  endtask : rchk

  // Presentation settles one edge after the request changes; checked after two
  task automatic see(input logic [1:0] l, input logic [7:0] ev);
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk({21'h00_0000, irq, lvl, vec}, {21'h00_0000, l != 2'b00, l, ev});
    // Hand back on a rising edge so the caller drives inputs there
    @(posedge clk);
  endtask : see

  // Let the core take the presented request at a random pace
  task automatic take;
    int n;
    n = 0;
    @(posedge clk);
    r = $random(seed);
    dly <= r[1:0];
    ack_en <= 1'b1;
    @(negedge clk);
    while (irq !== 1'b0 && n < 20) begin
      @(negedge clk);
      n++;
    end
    if (n >= 20) fail_count++;
    @(posedge clk);
    ack_en <= 1'b0;
  endtask : take

  task automatic end_of_test;
    $display("tests_run %0d fail_count %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_of_test

  // Main sequence
  initial begin
    seed = 32'h0000_60f0;
    fail_count = 0;
    tests_run = 0;
    req = '0;
    {gie, nmi, boot, ack_en, rst_n} = 5'b1_0000;
    dly = 2'h0;
    be = 4'hf;
    vreq = '0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    for (i = 0; i < 4; i++) rchk({i[1:0], 2'b00}, 8'h00);
    chk({16'h0000, pc}, 32'h0000_0000);
    bus(1'b1, 4'h0, 8'hff);
    rchk(4'h0, 8'h01);
    u_intc_core_model.unlock(3);
    bus(1'b1, 4'h0, 8'h61);
    rchk(4'h0, 8'h61);
    chk({30'h0000_0000, place, compact_table_enable}, 32'h0000_0003);
    boot <= 1'b1;
    @(negedge clk);
    chk({31'h0000_0000, place}, 32'h0000_0000);
    @(posedge clk);
    boot <= 1'b0;
    u_intc_core_model.unlock(4);
    bus(1'b1, 4'h0, 8'h00);
    rchk(4'h0, 8'h60);
    bus(1'b1, 4'h4, 8'hff);
    rchk(4'h4, 8'h00);
    bus(1'b1, 4'h9, 8'hff);
    chk(rq, 32'h0000_0000);
    // Pointer write with lane 0 disabled must not land
    be = 4'he;
    bus(1'b1, 4'h8, 8'h5a);
    be = 4'hf;
    rchk(4'h8, 8'h00);
    // Nested entry and return, compact table on then off
    for (c = 1; c >= 0; c--) begin
      bus(1'b1, 4'h0, 8'h01);
      rchk(4'h0, c ? 8'h61 : 8'h01);
      bus(1'b1, 4'hc, 8'h00);
      vreq <= 16'h0020;
      see(2'b01, c ? 8'h03 : 8'h05);
      take;
      rchk(4'h4, 8'h01);
      rchk(4'h8, 8'h05);
      bus(1'b1, 4'hc, 8'h07);
      vreq <= 16'h00a0;
      see(2'b11, c ? 8'h02 : 8'h07);
      take;
      rchk(4'h4, 8'h03);
      nmi <= 1'b1;
      see(2'b10, 8'h01);
      take;
      rchk(4'h4, 8'h83);
      nmi <= 1'b0;
      vreq <= '0;
      u_intc_core_model.ret;
      rchk(4'h4, 8'h03);
      u_intc_core_model.ret;
      rchk(4'h4, 8'h01);
      u_intc_core_model.ret;
      rchk(4'h4, 8'h00);
      u_intc_core_model.unlock(2);
      bus(1'b1, 4'h0, 8'h00);
    end
    // Zero level 1 selector puts vector 7 back in level 0
    bus(1'b1, 4'hc, 8'h00);
    // Fixed order from random pointers, first one at the wrap point
    for (i = 0; i < 8; i++) begin
      r = $random(seed);
      p = (i == 0) ? 8'h0f : {4'h0, r[3:0]};
      m = {r[19:7], r[6] | ~|r[19:7], r[5:4]};
      bus(1'b1, 4'h8, p);
      vreq <= m;
      see(2'b01, win(m, p));
      vreq <= '0;
    end
    end_of_test;
  end
endmodule : cpu_interrupt_priority_ctrl_tb_top
